/* File: design/cpu_operand_addressing.sv */
`timescale 1ns/1ps
`include "cpu_addr_map.svh"
module cpu_operand_addressing (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Instruction byte stream
  input wire logic byteValid,
  input wire logic [7:0] byteData,
  output logic byteReady,
  // Index register value
  input wire logic [7:0] indexReg,
  // Decoded operand plan
  output cpu_addr_pkg::addr_plan_t plan,
  input wire logic planAck,
  // Opcode past the opcode stage with no addressing mode seen
  output logic illegalOp
);
  cpu_addr_pkg::dec_state_t state;
  cpu_addr_pkg::dec_state_t next_state;
  cpu_addr_pkg::dec_info_t info;
  logic [7:0] opcodeReg;
  logic [7:0] oper1;
  logic [7:0] oper2;
  logic [7:0] idxAddr;
  logic idxMode;
  logic take;

  opcode_mode_decode u_dec (
    .opcode(opcodeReg),
    .info(info)
  );

  // Opcodes outside 0x00-0x3f, 0x5f and 0x5a-0x63 are dropped at the opcode stage
  function automatic logic knownOpcode(input logic [7:0] op);
    return op <= `OPC_ALU_GROUP_MAX || op == `OPC_MOVE_MM ||
           (op >= `OPC_MOVE_DIR_X && op <= `OPC_MOVE_REG_IDX_IMM);
  endfunction

  // Modes that add the index register to operand 1
  function automatic logic indexedMode(input cpu_addr_pkg::addr_mode_t m);
    return m == cpu_addr_pkg::MODE_SRC_IDX || m == cpu_addr_pkg::MODE_DST_IDX ||
           m == cpu_addr_pkg::MODE_DST_IDX_IMM;
  endfunction

  assign idxMode = indexedMode(info.mode);

  // RL3 index sum
  index_adder u_add (
    .base(oper1),
    .index(indexReg),
    .useIndex(idxMode),
    .addr(idxAddr)
  );

  assign byteReady = state != cpu_addr_pkg::ST_ISSUE;
  assign take = byteValid && byteReady;

  always_comb
  begin
    next_state = state;
    case (state)
      cpu_addr_pkg::ST_OPCODE:
        if (take)
          next_state = cpu_addr_pkg::ST_OPER1;
      cpu_addr_pkg::ST_OPER1:
        if (take)
        begin
          // RL4 two-byte forms end here
          if (info.length == `LEN_THREE)
            next_state = cpu_addr_pkg::ST_OPER2;
          else
            next_state = cpu_addr_pkg::ST_ISSUE;
        end
      cpu_addr_pkg::ST_OPER2:
        if (take)
          next_state = cpu_addr_pkg::ST_ISSUE;
      cpu_addr_pkg::ST_ISSUE:
        if (planAck)
          next_state = cpu_addr_pkg::ST_OPCODE;
      default: next_state = cpu_addr_pkg::ST_OPCODE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      state <= cpu_addr_pkg::ST_OPCODE;
    else if (state == cpu_addr_pkg::ST_OPCODE && take && !knownOpcode(byteData))
      state <= cpu_addr_pkg::ST_OPCODE;
    else
      state <= next_state;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      opcodeReg <= `ZERO8;
      oper1 <= `ZERO8;
      oper2 <= `ZERO8;
    end
    else if (take)
    begin
      case (state)
        cpu_addr_pkg::ST_OPCODE: opcodeReg <= byteData;
        cpu_addr_pkg::ST_OPER1: oper1 <= byteData;
        cpu_addr_pkg::ST_OPER2: oper2 <= byteData;
        default: oper2 <= oper2;
      endcase
    end
  end

  // Opcode past the opcode stage with no addressing mode handled here is flagged and holds the decoder in ST_ISSUE until planAck
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      illegalOp <= 1'b0;
    else
      illegalOp <= state == cpu_addr_pkg::ST_OPER1 && info.mode == cpu_addr_pkg::MODE_NONE && take;
  end

  // Plan register, loaded in ST_ISSUE the cycle after the last operand byte
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      plan <= '0;
    else if (state == cpu_addr_pkg::ST_ISSUE && planAck)
      plan.valid <= 1'b0;
    else if (state == cpu_addr_pkg::ST_ISSUE && !plan.valid)
    begin
      plan <= '0;
      plan.valid <= info.mode != cpu_addr_pkg::MODE_NONE;
      plan.mode <= info.mode;
      plan.length <= info.length;
      case (info.mode)
        cpu_addr_pkg::MODE_SRC_DIR, cpu_addr_pkg::MODE_SRC_IDX:
        begin
          // RL1 source at operand address, result to A or X
          plan.srcIsMem <= 1'b1;
          plan.srcRegSpace <= info.regSpace;
          plan.srcAddr <= idxAddr;
          plan.dstIsX <= info.useX;
          // RL2 second operand from the named register
          plan.secondFromX <= info.useX;
        end
        cpu_addr_pkg::MODE_DST_DIR, cpu_addr_pkg::MODE_DST_IDX:
        begin
          // RL5 RL15 destination in RAM or register space
          plan.dstIsMem <= 1'b1;
          plan.dstRegSpace <= info.regSpace;
          plan.dstAddr <= idxAddr;
          // RL6 RL8 source register choice
          plan.srcIsX <= info.mode == cpu_addr_pkg::MODE_DST_DIR && info.useX;
          // RL7 RL9 second operand from destination
          plan.secondFromMem <= !info.isMove;
        end
        cpu_addr_pkg::MODE_DST_DIR_IMM, cpu_addr_pkg::MODE_DST_IDX_IMM:
        begin
          // RL10 RL11 direct or indexed immediate target
          plan.dstIsMem <= 1'b1;
          plan.dstRegSpace <= info.regSpace;
          plan.dstAddr <= idxAddr;
          // RL10 literal source
          plan.immValue <= oper2;
          plan.secondFromMem <= !info.isMove;
        end
        cpu_addr_pkg::MODE_MEM_MEM:
        begin
          // RL13 RL14 RAM to RAM copy
          plan.srcIsMem <= 1'b1;
          plan.srcAddr <= oper2;
          plan.dstIsMem <= 1'b1;
          plan.dstAddr <= oper1;
        end
        default: plan.valid <= 1'b0;
      endcase
    end
  end

  // Plan for an undecodable opcode never issues
  logic issueStuck;
  assign issueStuck = state == cpu_addr_pkg::ST_ISSUE && info.mode == cpu_addr_pkg::MODE_NONE;

  // RL16 accumulator untouched when only a source
  chk_acc_src_only: assert property (@(posedge ref_clk) disable iff (!rstn) // RL16
    plan.valid && plan.dstIsMem |-> !plan.dstIsX)
    else $error("dest to memory also marks X");
  // RL14 copy stays in RAM
  chk_mm_ram_only: assert property (@(posedge ref_clk) disable iff (!rstn) // RL14
    plan.valid && plan.mode == cpu_addr_pkg::MODE_MEM_MEM |-> !plan.srcRegSpace && !plan.dstRegSpace)
    else $error("memory copy touches register space");
  // RL13 copy address order
  chk_mm_addr_order: assert property (@(posedge ref_clk) disable iff (!rstn) // RL13
    $rose(plan.valid) && plan.mode == cpu_addr_pkg::MODE_MEM_MEM |-> plan.srcAddr == oper2 && plan.dstAddr == oper1)
    else $error("memory copy addresses swapped");
  // RL4 two-byte length
  chk_len_two: assert property (@(posedge ref_clk) disable iff (!rstn) // RL4
    plan.valid && (plan.mode == cpu_addr_pkg::MODE_SRC_DIR || plan.mode == cpu_addr_pkg::MODE_DST_IDX)
    |-> plan.length == `LEN_TWO)
    else $error("two-byte length wrong");
  // RL12 three-byte length
  chk_len_three: assert property (@(posedge ref_clk) disable iff (!rstn) // RL12
    plan.valid && (plan.mode == cpu_addr_pkg::MODE_DST_IDX_IMM || plan.mode == cpu_addr_pkg::MODE_MEM_MEM)
    |-> plan.length == `LEN_THREE)
    else $error("three-byte length wrong");
  // RL3 indexed source sum
  chk_idx_sum: assert property (@(posedge ref_clk) disable iff (!rstn) // RL3
    $rose(plan.valid) && plan.mode == cpu_addr_pkg::MODE_SRC_IDX
    |-> plan.srcAddr == 8'($past(oper1) + $past(indexReg)))
    else $error("indexed source address wrong");
  // RL5 direct destination address
  chk_dir_addr: assert property (@(posedge ref_clk) disable iff (!rstn) // RL5
    $rose(plan.valid) && plan.mode == cpu_addr_pkg::MODE_DST_DIR |-> plan.dstAddr == oper1)
    else $error("direct destination address wrong");
  // RL10 literal source value
  chk_imm_literal: assert property (@(posedge ref_clk) disable iff (!rstn) // RL10
    $rose(plan.valid) && plan.mode == cpu_addr_pkg::MODE_DST_DIR_IMM |-> plan.immValue == oper2)
    else $error("immediate literal wrong");
  // RL8 indexed destination takes A
  chk_dstidx_acc: assert property (@(posedge ref_clk) disable iff (!rstn) // RL8
    plan.valid && plan.mode == cpu_addr_pkg::MODE_DST_IDX |-> !plan.srcIsX)
    else $error("indexed destination source not A");
  // RL4 two-byte plan timing
  chk_two_byte_timing: assert property (@(posedge ref_clk) disable iff (!rstn) // RL4
    state == cpu_addr_pkg::ST_OPER1 && take && info.length == `LEN_TWO
    |=> state == cpu_addr_pkg::ST_ISSUE ##1 (plan.valid || issueStuck))
    else $error("two-byte plan late");

  // RL1 direct source address
  chk_src_dir_addr: assert property (@(posedge ref_clk) disable iff (!rstn) // RL1
    $rose(plan.valid) && plan.mode == cpu_addr_pkg::MODE_SRC_DIR
    |-> plan.srcIsMem && plan.srcAddr == oper1)
    else $error("direct source address wrong");
  // RL1 result register choice
  chk_src_result_reg: assert property (@(posedge ref_clk) disable iff (!rstn) // RL1
    $rose(plan.valid) && (plan.mode == cpu_addr_pkg::MODE_SRC_DIR || plan.mode == cpu_addr_pkg::MODE_SRC_IDX)
    |-> plan.dstIsX == info.useX && !plan.dstIsMem)
    else $error("source mode result register wrong");
  // RL2 second operand register
  chk_src_second: assert property (@(posedge ref_clk) disable iff (!rstn) // RL2
    $rose(plan.valid) && (plan.mode == cpu_addr_pkg::MODE_SRC_DIR || plan.mode == cpu_addr_pkg::MODE_SRC_IDX)
    |-> plan.secondFromX == info.useX && !plan.secondFromMem)
    else $error("source mode second operand wrong");
  // RL3 indexed source space
  chk_src_space: assert property (@(posedge ref_clk) disable iff (!rstn) // RL3
    $rose(plan.valid) && plan.mode == cpu_addr_pkg::MODE_SRC_IDX
    |-> plan.srcIsMem && plan.srcRegSpace == info.regSpace)
    else $error("indexed source space wrong");
  // RL4 remaining two-byte forms
  chk_len_two_more: assert property (@(posedge ref_clk) disable iff (!rstn) // RL4
    plan.valid && (plan.mode == cpu_addr_pkg::MODE_SRC_IDX || plan.mode == cpu_addr_pkg::MODE_DST_DIR)
    |-> plan.length == `LEN_TWO)
    else $error("two-byte length wrong");
  // RL6 direct destination source
  chk_dst_src_reg: assert property (@(posedge ref_clk) disable iff (!rstn) // RL6
    $rose(plan.valid) && plan.mode == cpu_addr_pkg::MODE_DST_DIR
    |-> plan.srcIsX == info.useX)
    else $error("direct destination source register wrong");
  // RL7 direct destination second operand
  chk_dst_second: assert property (@(posedge ref_clk) disable iff (!rstn) // RL7
    $rose(plan.valid) && plan.mode == cpu_addr_pkg::MODE_DST_DIR && !info.isMove
    |-> plan.secondFromMem)
    else $error("direct second operand not from destination");
  // RL8 indexed destination address
  chk_dstidx_addr: assert property (@(posedge ref_clk) disable iff (!rstn) // RL8
    $rose(plan.valid) && plan.mode == cpu_addr_pkg::MODE_DST_IDX
    |-> plan.dstAddr == 8'($past(oper1) + $past(indexReg)))
    else $error("indexed destination address wrong");
  // RL9 indexed destination second operand
  chk_idx_second: assert property (@(posedge ref_clk) disable iff (!rstn) // RL9
    $rose(plan.valid) && indexedMode(plan.mode) && plan.dstIsMem && !info.isMove
    |-> plan.secondFromMem)
    else $error("indexed second operand not from destination");
  // RL10 direct immediate target
  chk_dirimm_addr: assert property (@(posedge ref_clk) disable iff (!rstn) // RL10
    $rose(plan.valid) && plan.mode == cpu_addr_pkg::MODE_DST_DIR_IMM
    |-> plan.dstIsMem && plan.dstAddr == oper1)
    else $error("direct immediate target wrong");
  // RL11 indexed immediate target
  chk_idximm_addr: assert property (@(posedge ref_clk) disable iff (!rstn) // RL11
    $rose(plan.valid) && plan.mode == cpu_addr_pkg::MODE_DST_IDX_IMM
    |-> plan.dstAddr == 8'($past(oper1) + $past(indexReg)) && plan.immValue == oper2)
    else $error("indexed immediate target wrong");
  // RL12 three-byte forms end after operand 2
  chk_three_byte_timing: assert property (@(posedge ref_clk) disable iff (!rstn) // RL12
    state == cpu_addr_pkg::ST_OPER2 && take
    |=> state == cpu_addr_pkg::ST_ISSUE)
    else $error("three-byte plan late");
  // RL13 copy only for the move opcode
  chk_mm_move_only: assert property (@(posedge ref_clk) disable iff (!rstn) // RL13
    $rose(plan.valid) && plan.mode == cpu_addr_pkg::MODE_MEM_MEM
    |-> info.isMove && opcodeReg == `OPC_MOVE_MM)
    else $error("memory copy from a non-move opcode");
  // RL15 destination space follows opcode
  chk_dst_space: assert property (@(posedge ref_clk) disable iff (!rstn) // RL15
    $rose(plan.valid) && plan.dstIsMem && plan.mode != cpu_addr_pkg::MODE_MEM_MEM
    |-> plan.dstRegSpace == info.regSpace)
    else $error("destination space wrong");
  // RL16 index sum wraps
  chk_idx_wrap: assert property (@(posedge ref_clk) disable iff (!rstn) // RL16
    idxMode
    |-> idxAddr == 8'(oper1 + indexReg))
    else $error("index sum does not wrap");

  cov_src_idx: cover property (@(posedge ref_clk) plan.valid && plan.mode == cpu_addr_pkg::MODE_SRC_IDX);
  cov_dst_imm: cover property (@(posedge ref_clk) plan.valid && plan.mode == cpu_addr_pkg::MODE_DST_IDX_IMM);
  cov_mem_mem: cover property (@(posedge ref_clk) plan.valid && plan.mode == cpu_addr_pkg::MODE_MEM_MEM);
  cov_reg_dst: cover property (@(posedge ref_clk) plan.valid && plan.dstRegSpace);
  cov_illegal: cover property (@(posedge ref_clk) illegalOp);
endmodule

/* File: design/cpu_addr_map.svh */
// Behaviour
// RL1: Source-direct reads source at operand byte address, result to A or X.
// RL2: Source-direct/indexed arithmetic takes second operand from opcode-chosen A or X.
// RL3: Source-indexed address is operand byte plus X, in RAM or register space.
// RL4: Source/destination direct and indexed instructions are two bytes long.
// RL5: Destination-direct writes result at location addressed by operand byte.
// RL6: Destination-direct source is A or X as the opcode selects.
// RL7: Destination-direct arithmetic uses current destination content as second operand.
// RL8: Destination-indexed address is operand plus X; source is accumulator.
// RL9: Indexed-destination arithmetic reads second operand from the same indexed location.
// RL10: Immediate-destination modes take source from second operand byte literally.
// RL11: Destination-indexed immediate address is operand byte plus X.
// RL12: Immediate-destination and memory-to-memory instructions are three bytes long.
// RL13: Memory-to-memory accepted only for move; copies RAM[op2] to RAM[op1].
// RL14: Memory-to-memory addresses refer to RAM only.
// RL15: Destination modes can target register space or RAM.
// RL16: Index sums wrap modulo 256; accumulator unchanged when only a source.
`ifndef CPU_ADDR_MAP_SVH
`define CPU_ADDR_MAP_SVH
`define LEN_TWO 2'h2
`define LEN_THREE 2'h3
`define LEN_ONE 2'h1
`define OPC_MOVE_MM 8'h5f
`define OPC_MOVE_A_REG_DIR 8'h5d
`define OPC_MOVE_A_REG_IDX 8'h5e
`define OPC_MOVE_REG_DIR_A 8'h60
`define OPC_MOVE_REG_IDX_A 8'h61
`define OPC_MOVE_REG_DIR_IMM 8'h62
`define OPC_MOVE_REG_IDX_IMM 8'h63
`define OPC_MOVE_DIR_X 8'h5a
`define OPC_ALU_GROUP_MAX 8'h3f
`define OPC_LOW_MASK 8'h07
`define OPC_XSRC_BIT 3
`define ZERO8 8'h00
`endif

/* File: design/cpu_addr_pkg.sv */
package cpu_addr_pkg;
  typedef enum logic [2:0] {
    MODE_NONE = 3'b000,
    MODE_SRC_DIR = 3'b001,
    MODE_SRC_IDX = 3'b010,
    MODE_DST_DIR = 3'b011,
    MODE_DST_IDX = 3'b100,
    MODE_DST_DIR_IMM = 3'b101,
    MODE_DST_IDX_IMM = 3'b110,
    MODE_MEM_MEM = 3'b111
  } addr_mode_t;

  typedef enum logic [1:0] {
    ST_OPCODE = 2'b00,
    ST_OPER1 = 2'b01,
    ST_OPER2 = 2'b10,
    ST_ISSUE = 2'b11
  } dec_state_t;

  typedef struct packed {
    addr_mode_t mode;
    logic regSpace;
    logic useX;
    logic isMove;
    logic [1:0] length;
  } dec_info_t;

  typedef struct packed {
    logic valid;
    addr_mode_t mode;
    logic [1:0] length;
    logic srcIsMem;
    logic srcRegSpace;
    logic [7:0] srcAddr;
    logic dstIsMem;
    logic dstRegSpace;
    logic [7:0] dstAddr;
    logic srcIsX;
    logic dstIsX;
    logic [7:0] immValue;
    logic secondFromMem;
    logic secondFromX;
  } addr_plan_t;
endpackage

/* File: design/opcode_mode_decode.sv */
`timescale 1ns/1ps
`include "cpu_addr_map.svh"
module opcode_mode_decode (
  // Opcode
  input wire logic [7:0] opcode,
  // Decoded info
  output cpu_addr_pkg::dec_info_t info
);
  logic [2:0] low;
  assign low = opcode[2:0] & 3'(`OPC_LOW_MASK);

  always_comb
  begin
    info.mode = cpu_addr_pkg::MODE_NONE;
    info.regSpace = 1'b0;
    info.useX = 1'b0;
    info.isMove = 1'b0;
    info.length = `LEN_ONE;
    // Arithmetic groups: low three bits give the mode
    if (opcode <= `OPC_ALU_GROUP_MAX && opcode != `ZERO8)
    begin
      info.useX = opcode[`OPC_XSRC_BIT];
      case (low)
        3'h2: info.mode = cpu_addr_pkg::MODE_SRC_DIR;
        3'h3: info.mode = cpu_addr_pkg::MODE_SRC_IDX;
        3'h4: info.mode = cpu_addr_pkg::MODE_DST_DIR;
        3'h5: info.mode = cpu_addr_pkg::MODE_DST_IDX;
        3'h6: info.mode = cpu_addr_pkg::MODE_DST_DIR_IMM;
        3'h7: info.mode = cpu_addr_pkg::MODE_DST_IDX_IMM;
        default: info.mode = cpu_addr_pkg::MODE_NONE;
      endcase
    end
    else
    begin
      info.isMove = 1'b1;
      case (opcode)
        `OPC_MOVE_A_REG_DIR:
        begin
          info.mode = cpu_addr_pkg::MODE_SRC_DIR;
          info.regSpace = 1'b1;
        end
        `OPC_MOVE_A_REG_IDX:
        begin
          info.mode = cpu_addr_pkg::MODE_SRC_IDX;
          info.regSpace = 1'b1;
        end
        `OPC_MOVE_DIR_X:
        begin
          info.mode = cpu_addr_pkg::MODE_DST_DIR;
          info.useX = 1'b1;
        end
        `OPC_MOVE_REG_DIR_A:
        begin
          info.mode = cpu_addr_pkg::MODE_DST_DIR;
          info.regSpace = 1'b1;
        end
        `OPC_MOVE_REG_IDX_A:
        begin
          info.mode = cpu_addr_pkg::MODE_DST_IDX;
          info.regSpace = 1'b1;
        end
        `OPC_MOVE_REG_DIR_IMM:
        begin
          info.mode = cpu_addr_pkg::MODE_DST_DIR_IMM;
          info.regSpace = 1'b1;
        end
        `OPC_MOVE_REG_IDX_IMM:
        begin
          info.mode = cpu_addr_pkg::MODE_DST_IDX_IMM;
          info.regSpace = 1'b1;
        end
        // RL13 move only
        `OPC_MOVE_MM: info.mode = cpu_addr_pkg::MODE_MEM_MEM;
        default: info.isMove = 1'b0;
      endcase
    end
    case (info.mode)
      cpu_addr_pkg::MODE_SRC_DIR, cpu_addr_pkg::MODE_SRC_IDX,
      cpu_addr_pkg::MODE_DST_DIR, cpu_addr_pkg::MODE_DST_IDX:
        // RL4 two bytes
        info.length = `LEN_TWO;
      cpu_addr_pkg::MODE_DST_DIR_IMM, cpu_addr_pkg::MODE_DST_IDX_IMM,
      cpu_addr_pkg::MODE_MEM_MEM:
        // RL12 three bytes
        info.length = `LEN_THREE;
      default: info.length = `LEN_ONE;
    endcase
  end
endmodule

/* File: design/index_adder.sv */
`timescale 1ns/1ps
module index_adder (
  // Operands
  input wire logic [7:0] base,
  input wire logic [7:0] index,
  input wire logic useIndex,
  // Address
  output logic [7:0] addr
);
  function automatic logic [7:0] wrapAdd(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[7:0];
  endfunction

  // RL16 wraps modulo 256
  assign addr = useIndex ? wrapAdd(base, index) : base;
endmodule

/* File: bench/plan_sink_model.sv */
`timescale 1ns/1ps
module plan_sink_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Plan from the decoder
  input wire cpu_addr_pkg::addr_plan_t plan,
  output logic planAck,
  // Behaviour set by the bench
  input wire logic [3:0] ackDelay,
  input wire logic ackAlways
);
  logic [3:0] waited;

  // Ack after a chosen wait; ackAlways frees a decoder held by a bad opcode
  // Launched on the rising edge so bench settings made at the falling edge never race it
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      waited <= 4'h0;
      planAck <= 1'b0;
    end
    else
    begin
      waited <= plan.valid ? waited + 4'h1 : 4'h0;
      planAck <= ackAlways || (plan.valid && waited >= ackDelay);
    end
  end
endmodule

/* File: bench/cpu_operand_addressing_test.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin err_total++; \
  $display("unexpected %s expected %h seen %h", nm, ex, gt); end end
module cpu_operand_addressing_test;
  logic ref_clk, rstn, byteValid, byteReady, planAck, illegalOp, ackAlways;
  logic [7:0] byteData, indexReg;
  logic [3:0] ackDelay;
  cpu_addr_pkg::addr_plan_t plan, got;
  int err_total, compares;

  cpu_operand_addressing dut (.ref_clk(ref_clk), .rstn(rstn), .byteValid(byteValid), .byteData(byteData),
    .byteReady(byteReady), .indexReg(indexReg), .plan(plan), .planAck(planAck), .illegalOp(illegalOp));
  plan_sink_model sink (.ref_clk(ref_clk), .rstn(rstn), .plan(plan), .planAck(planAck),
    .ackDelay(ackDelay), .ackAlways(ackAlways));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic stop_test();
    $display("mismatches %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic send(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2, input int n);
    logic [7:0] bs [3];
    bs = '{b0, b1, b2};
    for (int i = 0; i < n; i++)
    begin
      @(negedge ref_clk);
      byteValid = 1'b1;
      byteData = bs[i];
      for (int k = 0; k < 30 && byteReady !== 1'b1; k++)
        @(negedge ref_clk);
    end
    @(negedge ref_clk);
    byteValid = 1'b0;
  endtask

  task automatic run(input logic [7:0] opc, input logic [7:0] o1, input logic [7:0] o2, input int n);
    send(opc, o1, o2, n);
    for (int k = 0; k < 30 && plan.valid !== 1'b1; k++)
      @(negedge ref_clk);
    got = plan;
    `CHK("valid", 1'b1, got.valid);
    `CHK("length", 2'(n), got.length);
  endtask

  // ALU group, both register choices, index sum wrapping past 255
  task automatic alu_modes();
    logic [7:0] opc;
    logic [7:0] adr;
    cpu_addr_pkg::addr_mode_t mt [6];
    mt = '{cpu_addr_pkg::MODE_SRC_DIR, cpu_addr_pkg::MODE_SRC_IDX, cpu_addr_pkg::MODE_DST_DIR,
      cpu_addr_pkg::MODE_DST_IDX, cpu_addr_pkg::MODE_DST_DIR_IMM, cpu_addr_pkg::MODE_DST_IDX_IMM};
    indexReg = 8'hf0;
    for (int h = 0; h < 2; h++)
      for (int lo = 2; lo < 8; lo++)
      begin
        opc = 8'h10 + 8'(h * 8 + lo);
        adr = (lo % 2 == 1) ? 8'h10 : 8'h20;
        run(opc, 8'h20, 8'ha5, lo > 5 ? 3 : 2);
        `CHK("mode", mt[lo - 2], got.mode);
        if (lo < 4)
        begin
          `CHK("srcAddr", adr, got.srcAddr);
          `CHK("srcIsMem", 1'b1, got.srcIsMem);
          `CHK("dstIsX", 1'(h), got.dstIsX);
          `CHK("secondFromX", 1'(h), got.secondFromX);
        end
        else
        begin
          `CHK("dstAddr", adr, got.dstAddr);
          `CHK("dstIsMem", 1'b1, got.dstIsMem);
          `CHK("secondFromMem", 1'b1, got.secondFromMem);
        end
        if (lo == 4)
          `CHK("srcIsX", 1'(h), got.srcIsX);
        if (lo == 5)
          `CHK("srcIsX", 1'b0, got.srcIsX);
        if (lo > 5)
          `CHK("immValue", 8'ha5, got.immValue);
      end
  endtask

  // Move forms, register space targets and the memory copy under a slow consumer
  task automatic moves();
    indexReg = 8'hf0;
    run(8'h5d, 8'h20, 8'h00, 2);
    `CHK("srcRegSpace", 1'b1, got.srcRegSpace);
    `CHK("srcAddr", 8'h20, got.srcAddr);
    run(8'h5e, 8'h20, 8'h00, 2);
    `CHK("mode", cpu_addr_pkg::MODE_SRC_IDX, got.mode);
    `CHK("srcAddr", 8'h10, got.srcAddr);
    run(8'h60, 8'h20, 8'h00, 2);
    `CHK("dstRegSpace", 1'b1, got.dstRegSpace);
    `CHK("srcIsX", 1'b0, got.srcIsX);
    run(8'h61, 8'h20, 8'h00, 2);
    `CHK("dstAddr", 8'h10, got.dstAddr);
    run(8'h62, 8'h20, 8'h66, 3);
    `CHK("immValue", 8'h66, got.immValue);
    `CHK("dstRegSpace", 1'b1, got.dstRegSpace);
    run(8'h63, 8'h20, 8'h66, 3);
    `CHK("mode", cpu_addr_pkg::MODE_DST_IDX_IMM, got.mode);
    `CHK("dstAddr", 8'h10, got.dstAddr);
    run(8'h5a, 8'h20, 8'h00, 2);
    `CHK("srcIsX", 1'b1, got.srcIsX);
    `CHK("dstAddr", 8'h20, got.dstAddr);
    ackDelay = 4'h6;
    run(8'h5f, 8'h30, 8'h40, 3);
    `CHK("mode", cpu_addr_pkg::MODE_MEM_MEM, got.mode);
    `CHK("dstAddr", 8'h30, got.dstAddr);
    `CHK("srcAddr", 8'h40, got.srcAddr);
    `CHK("srcRegSpace", 1'b0, got.srcRegSpace);
    `CHK("dstRegSpace", 1'b0, got.dstRegSpace);
    repeat (3) @(negedge ref_clk);
    `CHK("planHeld", got, plan);
    `CHK("byteReady", 1'b0, byteReady);
    ackDelay = 4'h0;
  endtask

  // A dropped opcode, then an opcode with no mode here
  task automatic illegal_op();
    int pulses;
    int seen;
    pulses = 0;
    seen = 0;
    send(8'h80, 8'h00, 8'h00, 1);
    send(8'h11, 8'h20, 8'h00, 2);
    for (int k = 0; k < 8; k++)
    begin
      pulses += int'(illegalOp === 1'b1);
      seen += int'(plan.valid === 1'b1);
      @(negedge ref_clk);
    end
    `CHK("illegalPulses", 1, pulses);
    `CHK("illegalPlans", 0, seen);
    ackAlways = 1'b1;
    repeat (3) @(negedge ref_clk);
    ackAlways = 1'b0;
    run(8'h12, 8'h20, 8'h00, 2);
    `CHK("mode", cpu_addr_pkg::MODE_SRC_DIR, got.mode);
  endtask

  initial
  begin
    repeat (3000) @(posedge ref_clk);
    err_total++;
    stop_test();
  end

  initial
  begin
    rstn = 1'b0;
    byteValid = 1'b0;
    byteData = 8'h00;
    indexReg = 8'h00;
    ackDelay = 4'h0;
    ackAlways = 1'b0;
    err_total = 0;
    compares = 0;
    repeat (12) @(negedge ref_clk);
    rstn = 1'b1;
    alu_modes();
    moves();
    illegal_op();
    stop_test();
  end
endmodule
